// >>> smi_pkg.sv
// shared constants and types for the switch port data interfaces
package smi_pkg;
    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_MHZ      = 250;
    localparam int unsigned REF_CLK_MHZ      = 50;
    localparam int unsigned REF_DIV          = SYS_CLK_MHZ / REF_CLK_MHZ;
    localparam int unsigned REF_HALF_LO      = REF_DIV / 2;
    localparam int unsigned SLOW_REPEAT      = 10;
    localparam int unsigned MII_FAST_MHZ10   = 250;
    localparam int unsigned MII_SLOW_MHZ10   = 25;
    localparam int unsigned MII_FAST_DIV     = SYS_CLK_MHZ * 10 / MII_FAST_MHZ10;
    localparam int unsigned MII_SLOW_DIV     = SYS_CLK_MHZ * 10 / MII_SLOW_MHZ10;
    localparam int unsigned REF_LOSS_CYCLES  = 16;
    // ------------------------------------------------------------
    // frame layout and strap reset value
    // ------------------------------------------------------------
    localparam int unsigned PREAMBLE_BYTES   = 7;
    localparam logic [7:0]  PREAMBLE_BYTE    = 8'h55;
    localparam logic [7:0]  SFD_BYTE         = 8'hd5;
    localparam logic [31:0] CRC_INIT         = 32'hffffffff;
    localparam logic [31:0] CRC_POLY_REFL    = 32'hedb88320;
    localparam logic        STRAP_RESET      = 1'b0;

    typedef enum logic [1:0] {
        SMI_P5_MII   = 2'h0,
        SMI_P5_RMII  = 2'h1,
        SMI_P5_RGMII = 2'h3
    } smi_p5_mode_e;

    typedef enum logic [2:0] {
        SMI_TX_IDLE = 3'h0,
        SMI_TX_PRE  = 3'h1,
        SMI_TX_DATA = 3'h3,
        SMI_TX_CRC  = 3'h2,
        SMI_TX_GAP  = 3'h6
    } smi_tx_state_e;
endpackage

// >>> smi_link_if.sv
// pin-level link between the switch ports and the external partner
`timescale 1ns/1ps
interface smi_link_if;
    // port four reduced interface
    logic       port_four_ref_clock_out;
    logic       port_four_ref_clock_in;
    logic       port_four_carrier_valid_out;
    logic [1:0] port_four_rx_dibit;
    logic       port_four_tx_enable_in;
    logic [1:0] port_four_tx_dibit;
    // port five shared interface, named from the partner side
    logic       p5_tx_clk;
    logic       p5_tx_en;
    logic       p5_tx_er;
    logic [3:0] p5_txd;
    logic       p5_rx_clk;
    logic       p5_rx_dv;
    logic       p5_rx_er;
    logic [3:0] p5_rxd;
    logic       p5_crs;
    logic       p5_col;

    modport sw (
        output port_four_ref_clock_out, port_four_carrier_valid_out, port_four_rx_dibit,
        input  port_four_ref_clock_in, port_four_tx_enable_in, port_four_tx_dibit,
        output p5_rx_clk, p5_rx_dv, p5_rx_er, p5_rxd, p5_crs, p5_col, p5_tx_clk,
        input  p5_tx_en, p5_tx_er, p5_txd
    );
    modport partner (
        input  port_four_ref_clock_out, port_four_carrier_valid_out, port_four_rx_dibit,
        output port_four_ref_clock_in, port_four_tx_enable_in, port_four_tx_dibit,
        input  p5_rx_clk, p5_rx_dv, p5_rx_er, p5_rxd, p5_crs, p5_col, p5_tx_clk,
        output p5_tx_en, p5_tx_er, p5_txd
    );
endinterface

// >>> smi_switch_end.sv
// switch-side end: port four reduced interface and port five shared interface
`timescale 1ns/1ps
module smi_switch_end #(
    parameter int unsigned DIV_REF = smi_pkg::REF_DIV
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    smi_link_if.sw                    lnk,
    input  wire logic                 p4_clock_mode_strap,
    input  wire logic                 p4_clock_mode_reg,
    input  wire logic                 p4_clock_mode_sel_reg,
    input  wire logic                 p4_speed_100,
    input  wire logic                 p5_speed_100,
    input  wire smi_pkg::smi_p5_mode_e p5_mode,
    input  wire logic                 mac_phy_role_strap,
    input  wire logic                 p5_half_duplex,
    input  wire logic                 p4_out_valid,
    input  wire logic [1:0]           p4_out_dibit,
    output logic                      p4_out_take,
    input  wire logic                 p5_out_valid,
    input  wire logic [3:0]           p5_out_nibble,
    output logic                      p5_out_take,
    output logic                      p4_in_valid,
    output logic [1:0]                p4_in_dibit,
    output logic                      p4_in_frame,
    output logic                      p5_in_valid,
    output logic [3:0]                p5_in_nibble,
    output logic                      p5_in_frame,
    output logic                      p5_in_err,
    output logic                      p4_ref_ok,
    output logic                      p4_clock_mode,
    output logic                      p5_is_phy_role
);
    // ------------------------------------------------------------
    // strap capture after reset release
    // ------------------------------------------------------------
    logic strap_done_r;
    logic p4_strap_r;
    logic role_strap_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_r <= 1'b0;
            p4_strap_r   <= smi_pkg::STRAP_RESET;
            role_strap_r <= smi_pkg::STRAP_RESET;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            p4_strap_r   <= p4_clock_mode_strap;
            role_strap_r <= mac_phy_role_strap;
        end
    end
    // register bit overrides the strap once software selects it
    assign p4_clock_mode  = p4_clock_mode_sel_reg ? p4_clock_mode_reg : p4_strap_r;
    assign p5_is_phy_role = ~role_strap_r;

    // ------------------------------------------------------------
    // internal 50MHz reference divider
    // ------------------------------------------------------------
    logic [3:0] div_r;
    logic       ref_gen_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r     <= 4'h0;
            ref_gen_r <= 1'b0;
        end else begin
            div_r     <= (div_r == 4'(DIV_REF - 1)) ? 4'h0 : div_r + 4'h1;
            ref_gen_r <= (div_r < 4'(smi_pkg::REF_HALF_LO));
        end
    end
    assign lnk.port_four_ref_clock_out = p4_clock_mode ? ref_gen_r : 1'b0;
    // port five RMII clock always produced; MII clocks divided below
    logic p5_ref_internal;
    assign p5_ref_internal = (p5_mode == smi_pkg::SMI_P5_RMII);

    // ------------------------------------------------------------
    // external reference sampling and presence check
    // ------------------------------------------------------------
    logic [2:0] ext_sync_r;
    logic       ext_prev_r;
    logic [4:0] loss_cnt_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_sync_r <= 3'h0;
            ext_prev_r <= 1'b0;
            loss_cnt_r <= 5'h0;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], lnk.port_four_ref_clock_in};
            if (ext_sync_r[2] == ext_sync_r[1])
                ext_prev_r <= ext_sync_r[2];
            if (ext_sync_r[2] == ext_sync_r[1] && ext_sync_r[2] && !ext_prev_r)
                loss_cnt_r <= 5'h0;
            else if (loss_cnt_r != 5'(smi_pkg::REF_LOSS_CYCLES))
                loss_cnt_r <= loss_cnt_r + 5'h1;
        end
    end
    logic ext_rise;
    assign ext_rise  = (ext_sync_r[2] == ext_sync_r[1]) && ext_sync_r[2] && !ext_prev_r;
    assign p4_ref_ok = p4_clock_mode | (loss_cnt_r != 5'(smi_pkg::REF_LOSS_CYCLES));

    // ------------------------------------------------------------
    // port four di-bit strobe: one per reference cycle, ten at 10M
    // ------------------------------------------------------------
    logic p4_ref_tick;
    assign p4_ref_tick = p4_clock_mode ? (div_r == 4'h0) : ext_rise;
    logic [3:0] p4_rep_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            p4_rep_r <= 4'h0;
        else if (p4_ref_tick)
            p4_rep_r <= (p4_speed_100 || p4_rep_r == 4'(smi_pkg::SLOW_REPEAT - 1)) ? 4'h0 : p4_rep_r + 4'h1;
    end
    logic p4_step;
    assign p4_step = p4_ref_tick && p4_ref_ok && (p4_speed_100 || p4_rep_r == 4'h0);

    // same pins serve either partner role, so no role selection exists
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lnk.port_four_carrier_valid_out <= 1'b0;
            lnk.port_four_rx_dibit          <= 2'h0;
        end else if (p4_step) begin
            lnk.port_four_carrier_valid_out <= p4_out_valid;
            lnk.port_four_rx_dibit          <= p4_out_dibit;
        end
    end
    assign p4_out_take = p4_step;

    // received di-bits sampled on the reference edge, tx path separate
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            p4_in_valid <= 1'b0;
            p4_in_dibit <= 2'h0;
            p4_in_frame <= 1'b0;
        end else begin
            p4_in_valid <= p4_step & lnk.port_four_tx_enable_in;
            if (p4_step) begin
                p4_in_dibit <= lnk.port_four_tx_dibit;
                p4_in_frame <= lnk.port_four_tx_enable_in;
            end
        end
    end

    // ------------------------------------------------------------
    // port five: MII, RMII or RGMII chosen by p5_mode, clock produced here
    // ------------------------------------------------------------
    logic [6:0] p5_div_r;
    logic       p5_clk_r;
    logic [6:0] p5_lim;
    always_comb begin
        if (p5_ref_internal)
            p5_lim = 7'(DIV_REF - 1);
        else if (p5_speed_100)
            p5_lim = 7'(smi_pkg::MII_FAST_DIV - 1);
        else
            p5_lim = 7'(smi_pkg::MII_SLOW_DIV - 1);
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            p5_div_r <= 7'h0;
            p5_clk_r <= 1'b0;
        end else begin
            p5_div_r <= (p5_div_r >= p5_lim) ? 7'h0 : p5_div_r + 7'h1;
            p5_clk_r <= (p5_div_r <= (p5_lim >> 1));
        end
    end
    assign lnk.p5_rx_clk = p5_clk_r;
    assign lnk.p5_tx_clk = p5_clk_r;
    logic [3:0] p5_rep_r;
    logic       p5_tick;
    assign p5_tick = (p5_div_r == 7'h0);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            p5_rep_r <= 4'h0;
        else if (p5_tick && p5_ref_internal)
            p5_rep_r <= (p5_speed_100 || p5_rep_r == 4'(smi_pkg::SLOW_REPEAT - 1)) ? 4'h0 : p5_rep_r + 4'h1;
    end
    logic p5_step;
    assign p5_step = p5_tick && (!p5_ref_internal || p5_speed_100 || p5_rep_r == 4'h0);
    // rmii uses low two bits; rgmii at 10/100 behaves as the nibble path
    logic [3:0] p5_mask;
    assign p5_mask = p5_ref_internal ? 4'h3 : 4'hf;

    logic tx_busy;
    assign tx_busy = p5_out_valid;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lnk.p5_rx_dv <= 1'b0;
            lnk.p5_rx_er <= 1'b0;
            lnk.p5_rxd   <= 4'h0;
            lnk.p5_crs   <= 1'b0;
            lnk.p5_col   <= 1'b0;
        end else if (p5_step) begin
            lnk.p5_rx_dv <= p5_out_valid;
            lnk.p5_rx_er <= 1'b0;
            lnk.p5_rxd   <= p5_out_nibble & p5_mask;
            lnk.p5_crs   <= (tx_busy | lnk.p5_tx_en) && p5_mode == smi_pkg::SMI_P5_MII;
            // collision only meaningful when sharing the medium
            lnk.p5_col   <= p5_half_duplex && tx_busy && lnk.p5_tx_en
                            && p5_mode == smi_pkg::SMI_P5_MII;
        end
    end
    assign p5_out_take = p5_step;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            p5_in_valid  <= 1'b0;
            p5_in_nibble <= 4'h0;
            p5_in_frame  <= 1'b0;
            p5_in_err    <= 1'b0;
        end else begin
            p5_in_valid <= p5_step & lnk.p5_tx_en;
            if (p5_step) begin
                p5_in_nibble <= lnk.p5_txd & p5_mask;
                p5_in_frame  <= lnk.p5_tx_en;
                p5_in_err    <= lnk.p5_tx_er && p5_mode == smi_pkg::SMI_P5_MII;
            end
        end
    end
    // gigabit double-edge transfer is outside this core clock rate
    logic unused_rgmii;
    assign unused_rgmii = (p5_mode == smi_pkg::SMI_P5_RGMII);
endmodule

// >>> smi_partner_end.sv
// partner end: external MAC or PHY facing both switch ports
`timescale 1ns/1ps
module smi_partner_end (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    smi_link_if.partner     lnk,
    input  wire logic       ref_osc_en,
    input  wire logic       p4_speed_100,
    input  wire logic       p5_speed_100,
    input  wire smi_pkg::smi_p5_mode_e p5_mode,
    input  wire logic       tx4_valid,
    input  wire logic [1:0] tx4_dibit,
    input  wire logic       tx5_valid,
    input  wire logic [3:0] tx5_nibble,
    input  wire logic       tx5_err,
    output logic            tx4_take,
    output logic            tx5_take,
    output logic            rx4_valid,
    output logic [1:0]      rx4_dibit,
    output logic            rx5_valid,
    output logic [3:0]      rx5_nibble,
    output logic            rx5_crs,
    output logic            rx5_col
);
    // ------------------------------------------------------------
    // reference for external mode, divided from own clock
    // ------------------------------------------------------------
    logic [3:0] div_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            div_r <= 4'h0;
        else
            div_r <= (div_r == 4'(smi_pkg::REF_DIV - 1)) ? 4'h0 : div_r + 4'h1;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            lnk.port_four_ref_clock_in <= 1'b0;
        else
            lnk.port_four_ref_clock_in <= ref_osc_en && (div_r < 4'(smi_pkg::REF_HALF_LO));
    end

    // ------------------------------------------------------------
    // link clocks: sampled through three stages, edges on agreement
    // ------------------------------------------------------------
    logic [2:0] c4_r;
    logic [2:0] c5_r;
    logic       c4_prev_r;
    logic       c5_prev_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            c4_r      <= 3'h0;
            c5_r      <= 3'h0;
            c4_prev_r <= 1'b0;
            c5_prev_r <= 1'b0;
        end else begin
            c4_r <= {c4_r[1:0], lnk.port_four_ref_clock_out | lnk.port_four_ref_clock_in};
            c5_r <= {c5_r[1:0], lnk.p5_rx_clk};
            if (c4_r[2] == c4_r[1])
                c4_prev_r <= c4_r[2];
            if (c5_r[2] == c5_r[1])
                c5_prev_r <= c5_r[2];
        end
    end
    logic e4;
    logic e5;
    assign e4 = (c4_r[2] == c4_r[1]) && c4_r[2] && !c4_prev_r;
    assign e5 = (c5_r[2] == c5_r[1]) && c5_r[2] && !c5_prev_r;
    // at 10 Mb/s a port four or RMII unit stands for ten reference edges; counted from reset so both ends agree
    logic [3:0] rep4_r;
    logic [3:0] rep5_r;
    logic       rmii5;
    logic       s4;
    logic       s5;
    assign rmii5 = (p5_mode == smi_pkg::SMI_P5_RMII);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rep4_r <= 4'h0;
            rep5_r <= 4'h0;
        end else begin
            if (e4)
                rep4_r <= (p4_speed_100 || rep4_r == 4'(smi_pkg::SLOW_REPEAT - 1)) ? 4'h0 : rep4_r + 4'h1;
            if (e5 && rmii5)
                rep5_r <= (p5_speed_100 || rep5_r == 4'(smi_pkg::SLOW_REPEAT - 1)) ? 4'h0 : rep5_r + 4'h1;
        end
    end
    assign s4 = e4 && (p4_speed_100 || rep4_r == 4'h0);
    assign s5 = e5 && (!rmii5 || p5_speed_100 || rep5_r == 4'h0);
    assign tx4_take = s4;
    assign tx5_take = s5;

    // partner drives tx pins, crossing roles is pure wiring outside
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lnk.port_four_tx_enable_in <= 1'b0;
            lnk.port_four_tx_dibit     <= 2'h0;
            lnk.p5_tx_en               <= 1'b0;
            lnk.p5_tx_er               <= 1'b0;
            lnk.p5_txd                 <= 4'h0;
        end else begin
            if (s4) begin
                lnk.port_four_tx_enable_in <= tx4_valid;
                lnk.port_four_tx_dibit     <= tx4_dibit;
            end
            if (s5) begin
                lnk.p5_tx_en <= tx5_valid;
                lnk.p5_tx_er <= tx5_err;
                lnk.p5_txd   <= tx5_nibble;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx4_valid  <= 1'b0;
            rx4_dibit  <= 2'h0;
            rx5_valid  <= 1'b0;
            rx5_nibble <= 4'h0;
            rx5_crs    <= 1'b0;
            rx5_col    <= 1'b0;
        end else begin
            rx4_valid <= s4 & lnk.port_four_carrier_valid_out;
            rx5_valid <= s5 & lnk.p5_rx_dv;
            if (s4)
                rx4_dibit <= lnk.port_four_rx_dibit;
            if (s5) begin
                rx5_nibble <= lnk.p5_rxd;
                rx5_crs    <= lnk.p5_crs;
                rx5_col    <= lnk.p5_col;
            end
        end
    end
endmodule

// >>> smi_link_assertions.sv
// concurrent checks on the pins between the switch end and the partner end
`timescale 1ns/1ps
module smi_link_assertions (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       port_four_ref_clock_out,
    input wire logic [1:0] port_four_rx_dibit,
    input wire logic [1:0] port_four_tx_dibit,
    input wire logic       p5_tx_clk,
    input wire logic       p5_rx_clk,
    input wire logic       p5_rx_dv,
    input wire logic [3:0] p5_rxd,
    input wire logic [3:0] p5_txd,
    input wire logic       p5_crs,
    input wire logic       p5_col
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // link clocks
    // ------------------------------------------------------------
    chk_ref_out_period: assert property ($rose(port_four_ref_clock_out) |-> ##5 $rose(port_four_ref_clock_out))
        else $error("port four reference out does not repeat every five cycles");
    chk_p5_clk_shared: assert property (p5_tx_clk == p5_rx_clk)
        else $error("port five transmit and receive clocks differ");
    chk_p5_clk_min: assert property ($rose(p5_rx_clk) |=> !$rose(p5_rx_clk) [*4])
        else $error("port five clock faster than the reference");
    // quiet pins while reset is low; async reset so no disable here
    chk_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !port_four_ref_clock_out && !p5_rx_dv && !p5_col)
        else $error("link outputs active during reset");
    // ------------------------------------------------------------
    // data stepping: a unit holds at least one reference period
    // ------------------------------------------------------------
    chk_p4_rx_hold: assert property ($changed(port_four_rx_dibit) |=> $stable(port_four_rx_dibit) [*4])
        else $error("port four receive di-bit changed within a step");
    chk_p4_tx_hold: assert property ($changed(port_four_tx_dibit) |=> $stable(port_four_tx_dibit) [*4])
        else $error("port four transmit di-bit changed within a step");
    chk_p5_rx_hold: assert property ($changed(p5_rxd) |=> $stable(p5_rxd) [*4])
        else $error("port five receive nibble changed within a step");
    chk_p5_tx_hold: assert property ($changed(p5_txd) |=> $stable(p5_txd) [*4])
        else $error("port five transmit nibble changed within a step");
    chk_col_with_crs: assert property (p5_col |-> p5_crs)
        else $error("collision without carrier sense");
    cov_ref_out: cover property ($rose(port_four_ref_clock_out));
    cov_p5_frame: cover property ($rose(p5_rx_dv));
    cov_col: cover property ($rose(p5_col));
endmodule

// >>> test_switch_port_mii_rmii_interface.sv
// self-checking bench: switch end and partner end joined by the link interface
`timescale 1ns/1ps
module test_switch_port_mii_rmii_interface;
    logic       ref_clk = 1'b0, rst_n = 1'b0, osc = 1'b0;
    logic       strap4 = 1'b0, mreg = 1'b0, msel = 1'b0, sp4 = 1'b0, sp5 = 1'b0, hd = 1'b0, role = 1'b0;
    smi_pkg::smi_p5_mode_e mode5 = smi_pkg::SMI_P5_RMII;
    logic       o4v = 1'b0, o5v = 1'b0, t4v = 1'b0, t5v = 1'b0, t5e = 1'b0, i5e, saw_err = 1'b0;
    logic [1:0] o4d = 2'h0, t4d = 2'h0;
    logic [3:0] o5d = 4'h0, t5d = 4'h0;
    logic       o4k, o5k, t4k, t5k, i4v, i4f, i5v, i5f, r4v, r5v, r5c, r5l, ref_ok, cmode, phy;
    logic [1:0] i4d, r4d;
    logic [3:0] i5d, r5d;
    logic       k4 = 1'b0, k5 = 1'b0, kt4 = 1'b0, kt5 = 1'b0, saw_col = 1'b0, saw_crs = 1'b0;
    logic [3:0] sq[4][$];  // to send: sw p4, sw p5, partner p4, partner p5
    logic [3:0] rq[4][$];  // seen at the opposite end, same order
    int         failures = 0, n_compared = 0;

    always #2 ref_clk = ~ref_clk;
    // ------------------------------------------------------------
    // ends under test
    // ------------------------------------------------------------
    smi_link_if lnk();
    smi_switch_end smi_switch_end_i (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk),
        .p4_clock_mode_strap(strap4), .p4_clock_mode_reg(mreg), .p4_clock_mode_sel_reg(msel),
        .p4_speed_100(sp4), .p5_speed_100(sp5), .p5_mode(mode5), .mac_phy_role_strap(role),
        .p5_half_duplex(hd), .p4_out_valid(o4v), .p4_out_dibit(o4d), .p4_out_take(o4k),
        .p5_out_valid(o5v), .p5_out_nibble(o5d), .p5_out_take(o5k), .p4_in_valid(i4v),
        .p4_in_dibit(i4d), .p4_in_frame(i4f), .p5_in_valid(i5v), .p5_in_nibble(i5d),
        .p5_in_frame(i5f), .p5_in_err(i5e), .p4_ref_ok(ref_ok), .p4_clock_mode(cmode), .p5_is_phy_role(phy));
    smi_partner_end smi_partner_end_i (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk), .ref_osc_en(osc),
        .p4_speed_100(sp4), .p5_speed_100(sp5), .p5_mode(mode5),
        .tx4_valid(t4v), .tx4_dibit(t4d), .tx5_valid(t5v), .tx5_nibble(t5d), .tx5_err(t5e),
        .tx4_take(t4k), .tx5_take(t5k), .rx4_valid(r4v), .rx4_dibit(r4d), .rx5_valid(r5v),
        .rx5_nibble(r5d), .rx5_crs(r5c), .rx5_col(r5l));
    smi_link_assertions smi_link_assertions_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .port_four_ref_clock_out(lnk.port_four_ref_clock_out), .port_four_rx_dibit(lnk.port_four_rx_dibit),
        .port_four_tx_dibit(lnk.port_four_tx_dibit), .p5_tx_clk(lnk.p5_tx_clk), .p5_rx_clk(lnk.p5_rx_clk),
        .p5_rx_dv(lnk.p5_rx_dv), .p5_rxd(lnk.p5_rxd), .p5_txd(lnk.p5_txd), .p5_crs(lnk.p5_crs),
        .p5_col(lnk.p5_col));
    // ------------------------------------------------------------
    // user-side drivers and monitors
    // ------------------------------------------------------------
    // take is combinational, so it is caught mid-cycle to avoid an edge race
    always @(negedge ref_clk) begin
        k4 = o4k;
        k5 = o5k;
        kt4 = t4k;
        kt5 = t5k;
        if (r4v === 1'b1) rq[0].push_back({2'h0, r4d});
        if (r5v === 1'b1) rq[1].push_back(r5d);
        if (i4v === 1'b1 && i4f === 1'b1) rq[2].push_back({2'h0, i4d});
        if (i5v === 1'b1 && i5f === 1'b1) rq[3].push_back(i5d);
        if (r5l === 1'b1) saw_col = 1'b1;
        if (r5c === 1'b1) saw_crs = 1'b1;
        if (i5v === 1'b1 && i5e === 1'b1) saw_err = 1'b1;
    end
    always @(posedge ref_clk) begin
        if (k4 && o4v) void'(sq[0].pop_front());
        if (k5 && o5v) void'(sq[1].pop_front());
        if (kt4 && t4v) void'(sq[2].pop_front());
        if (kt5 && t5v) void'(sq[3].pop_front());
        o4v <= sq[0].size() > 0;
        o4d <= sq[0].size() > 0 ? sq[0][0][1:0] : 2'h0;
        o5v <= sq[1].size() > 0;
        o5d <= sq[1].size() > 0 ? sq[1][0] : 4'h0;
        t4v <= sq[2].size() > 0;
        t4d <= sq[2].size() > 0 ? sq[2][0][1:0] : 2'h0;
        t5v <= sq[3].size() > 0;
        t5d <= sq[3].size() > 0 ? sq[3][0] : 4'h0;
        t5e <= sq[3].size() > 0 ? sq[3][0][3] : 1'b0;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [3:0] pat(input int d, input int i);
        return 4'(i * 5 + d * 3 + 1);
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // eight units each way on both ports at once; late holds the port four reference back
    task automatic run_case(input string name, input logic st, ms, mr, os, s4, s5,
                            input smi_pkg::smi_p5_mode_e md, input logic h, rl, late);
        int t;
        logic [3:0] m;
        begin
            @(posedge ref_clk);
            rst_n <= 1'b0;
            strap4 <= st;
            msel <= ms;
            mreg <= mr;
            osc <= os && !late;
            sp4 <= s4;
            sp5 <= s5;
            mode5 <= md;
            hd <= h;
            role <= rl;
            repeat (5) @(posedge ref_clk);
            rst_n <= 1'b1;
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            saw_col = 1'b0;
            saw_crs = 1'b0;
            saw_err = 1'b0;
            for (int d = 0; d < 4; d++) begin
                rq[d].delete();
                for (int i = 0; i < 8; i++) sq[d].push_back(pat(d, i));
            end
            if (late) begin
                repeat (300) @(negedge ref_clk);
                check("ref_ok without reference", {7'h0, ref_ok}, 8'h00);
                check("p4 units without reference", 8'(rq[0].size() + rq[2].size()), 8'h00);
                @(posedge ref_clk);
                osc <= 1'b1;
            end
            t = 0;
            while ((rq[0].size() < 8 || rq[1].size() < 8 || rq[2].size() < 8 || rq[3].size() < 8) && t < 4000) begin
                @(negedge ref_clk);
                t++;
            end
            m = (md == smi_pkg::SMI_P5_RMII) ? 4'h3 : 4'hf;
            check("clock mode", {7'h0, cmode}, {7'h0, ms ? mr : st});
            check("phy role", {7'h0, phy}, {7'h0, ~rl});
            check("carrier seen", {7'h0, saw_crs}, {7'h0, md == smi_pkg::SMI_P5_MII});
            check("collision seen", {7'h0, saw_col}, {7'h0, md == smi_pkg::SMI_P5_MII && h});
            check("error seen", {7'h0, saw_err}, {7'h0, md == smi_pkg::SMI_P5_MII});
            for (int d = 0; d < 4; d++) begin
                check("units received", 8'(rq[d].size()), 8'h08);
                for (int i = 0; i < 8 && i < rq[d].size(); i++)
                    check("unit value", {4'h0, rq[d][i]}, {4'h0, pat(d, i) & (d[0] ? m : 4'h3)});
            end
            $display("case %s done", name);
        end
    endtask
    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        run_case("p4 clock mode 100, p5 rmii 100", 1, 0, 0, 0, 1, 1, smi_pkg::SMI_P5_RMII, 0, 0, 0);
        run_case("p4 external 10, p5 mii 100 half", 0, 0, 0, 1, 0, 1, smi_pkg::SMI_P5_MII, 1, 1, 0);
        run_case("p4 late reference, p5 mii 10", 0, 0, 0, 1, 1, 0, smi_pkg::SMI_P5_MII, 0, 0, 1);
        run_case("p4 register clock mode, p5 rgmii", 0, 1, 1, 0, 1, 1, smi_pkg::SMI_P5_RGMII, 0, 1, 0);
        run_case("p5 rmii 10 half", 1, 0, 0, 0, 0, 0, smi_pkg::SMI_P5_RMII, 1, 0, 0);
        report_and_stop();
    end
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
endmodule
